// [src/scss_pkg.sv]
// Function
// - four clock modes: external low, medium, high power, and internal
// - configuration clock bits pick the source at power-up and reset
// - external modes take a logic clock; clock out pin is I/O or clock
// - external modes bypass the start-up timer, no added delay
// - logic fully static; stopped clock keeps all state
// - internal mode frees clock input pin; config bit sets clock out pin
// - select field 1x switches to internal output chosen by freq field
// - 16 MHz source made from 500 kHz via lock loop, then postscaler
// - high source on when freq field picks it and config 00 or select 1x
// - status shows high source ready, locked within 2%, stable within 0.5%
// - mid source feeds postscaler of five frequencies, same enables
// - mid ready flag set while mid oscillator runs
// - trim is 6-bit signed, reset zero, acts on mid and high sources
// - trim write drifts frequency; no completion flag given
// - trim never touches the low-frequency oscillator
// - low oscillator on for code 0000 with select 1x; clocks timers
// - low ready flag set while low oscillator runs
// - fast start-up oscillator runs before switching to high source
// - select 00 uses configuration source; reset clears select field
// - reset loads frequency field with 0111, 500 kHz
// - switch waits falling edge of old clock, holds low, new rising edge
// - code 1111 gives 16 MHz, 1110 gives 8 MHz from high source
package scss_pkg;
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_TRIM = 2'h2;
  // control register fields
  localparam int CTRL_SCS_LSB = 0;
  localparam int CTRL_IFS_LSB = 3;
  localparam logic [1:0] SCS_RESET = 2'h0;
  localparam logic [3:0] IFS_RESET = 4'h7;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  // status register bit positions
  localparam int STAT_HF_STABLE = 0;
  localparam int STAT_HF_LOCKED = 1;
  localparam int STAT_HF_READY = 2;
  localparam int STAT_LF_READY = 3;
  localparam int STAT_MF_READY = 4;
  // configuration clock codes
  localparam logic [1:0] FOSC_INT = 2'h0;
  localparam logic [1:0] FOSC_EXT_LOW = 2'h1;
  localparam logic [1:0] FOSC_EXT_MID = 2'h2;
  localparam logic [1:0] FOSC_EXT_HIGH = 2'h3;
  // frequency codes with special meaning
  localparam logic [3:0] IFS_LF = 4'h0;
  localparam logic [3:0] IFS_HF_16M = 4'hF;
  localparam logic [3:0] IFS_HF_8M = 4'hE;
  localparam logic [3:0] IFS_MF_TOP = 4'h7;
  localparam logic [3:0] IFS_MF_DIV16 = 4'h4;
  localparam logic [2:0] MF_DIV_MAX = 3'h4;
  // timing, figures in ns, counts in 50 ns core cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int HF_READY_NS = 5000;
  localparam int HF_LOCK_NS = 20000;
  localparam int HF_STABLE_NS = 50000;
  localparam int MF_READY_NS = 2000;
  localparam int LF_READY_NS = 10000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] HF_READY_CYC =
    CNT_W'((HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_LOCK_CYC =
    CNT_W'((HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_STABLE_CYC =
    CNT_W'((HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MF_READY_CYC =
    CNT_W'((MF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LF_READY_CYC =
    CNT_W'((LF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // clock sources, codes index the synchroniser bank
  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_HF = 2'b01,
    SRC_MF = 2'b10,
    SRC_LF = 2'b11
  } scss_src_e;
  // switch sequencer
  typedef enum logic [2:0] {
    SW_BOOT = 3'b000,
    SW_RUN = 3'b001,
    SW_WAIT_RDY = 3'b010,
    SW_WAIT_FALL = 3'b011,
    SW_HOLD = 3'b100
  } scss_state_e;
endpackage

// [src/scss_sync.sv]
`timescale 1ns/1ns
module scss_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } scss_sync_s;

  scss_sync_s st_q;
  scss_sync_s st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule // scss_sync

// [src/scss_top.sv]
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module scss_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [scss_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [scss_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [scss_pkg::DATA_W-1:0] reg_rdata_out,
  // configuration word and timer needs
  input wire logic [1:0] fosc_cfg_in,
  input wire logic clock_out_pin_cfg_in,
  input wire logic wdt_needs_lf_in,
  input wire logic powerup_delay_timer_needs_lf_in,
  // raw oscillator and pin levels
  input wire logic ext_clock_in_pin_in,
  input wire logic hf_osc_lvl_in,
  input wire logic mf_osc_lvl_in,
  input wire logic lf_osc_lvl_in,
  // general purpose drive for the clock out pin
  input wire logic gpio_out_in,
  input wire logic gpio_oe_in,
  // oscillator controls
  output logic hf_osc_en_out,
  output logic mf_osc_en_out,
  output logic lf_osc_en_out,
  output logic fast_start_en_out,
  output logic [5:0] osc_trim_out,
  // system clock selection
  output logic [1:0] sys_clk_src_out,
  output logic [2:0] sys_clk_div_out,
  output logic sys_clk_hold_out,
  output logic startup_bypass_out,
  output logic [1:0] ext_power_mode_out,
  // pins
  output logic ext_pin_gpio_free_out,
  output logic clock_out_pin_out,
  output logic clock_out_pin_oe_out
);
  import scss_pkg::*;

  typedef struct packed {
    scss_state_e st;
    scss_src_e cur_src;
    logic [2:0] cur_div;
    scss_src_e pend_src;
    logic [2:0] pend_div;
    logic [1:0] sys_clk_select;
    logic [3:0] ifs;
    logic [5:0] trim;
    logic [CNT_W-1:0] hf_cnt;
    logic [CNT_W-1:0] mf_cnt;
    logic [CNT_W-1:0] lf_cnt;
    logic hf_en;
    logic mf_en;
    logic lf_en;
    logic hf_rdy;
    logic hf_lck;
    logic hf_stb;
    logic mf_rdy;
    logic lf_rdy;
    logic fso_en;
    logic hold;
    logic cur_lvl_p;
    logic new_lvl_p;
    logic [DATA_W-1:0] rdata;
    logic bypass;
    logic [1:0] ext_mode;
    logic gpio_free;
    logic cko;
    logic cko_oe;
  } scss_top_s;

  scss_top_s st_q;
  scss_top_s st_d;
  logic [3:0] lvl_sync;
  logic int_mode;
  scss_src_e tgt_src;
  logic [2:0] tgt_div;
  logic cur_lvl;
  logic new_lvl;
  logic new_rdy;
  logic [DATA_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] stat_rd;

  // every clock level comes from another domain
  scss_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in({lf_osc_lvl_in, mf_osc_lvl_in, hf_osc_lvl_in,
               ext_clock_in_pin_in}),
    .sync_out(lvl_sync)
  );

  // source and postscaler decode from the selection fields
  always_comb begin
    int_mode = (fosc_cfg_in == FOSC_INT) || st_q.sys_clk_select[1];
    tgt_src = SRC_EXT;
    tgt_div = 3'h0;
    if (!int_mode) begin
      tgt_src = SRC_EXT;
    end else if (st_q.ifs[3]) begin
      // 1111 undivided 16 MHz, 1110 halved to 8 MHz
      tgt_src = SRC_HF;
      tgt_div = 3'(IFS_HF_16M - st_q.ifs);
    end else if (st_q.ifs == IFS_LF) begin
      tgt_src = SRC_LF;
    end else if (st_q.ifs >= IFS_MF_DIV16) begin
      tgt_src = SRC_MF;
      tgt_div = 3'(IFS_MF_TOP - st_q.ifs);
    end else begin
      // low codes all give the same divided mid frequency
      tgt_src = SRC_MF;
      tgt_div = MF_DIV_MAX;
    end
  end

  // levels of the running and the pending clock
  always_comb begin
    cur_lvl = lvl_sync[st_q.cur_src];
    new_lvl = lvl_sync[st_q.pend_src];
    unique case (st_q.pend_src)
      SRC_EXT: new_rdy = 1'b1;
      SRC_HF: new_rdy = st_q.hf_rdy;
      SRC_MF: new_rdy = st_q.mf_rdy;
      SRC_LF: new_rdy = st_q.lf_rdy;
    endcase
  end

  // register readback images
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_SCS_LSB +: 2] = st_q.sys_clk_select;
    ctrl_rd[CTRL_IFS_LSB +: 4] = st_q.ifs;
    stat_rd = '0;
    stat_rd[STAT_HF_STABLE] = st_q.hf_stb;
    stat_rd[STAT_HF_LOCKED] = st_q.hf_lck;
    stat_rd[STAT_HF_READY] = st_q.hf_rdy;
    stat_rd[STAT_LF_READY] = st_q.lf_rdy;
    stat_rd[STAT_MF_READY] = st_q.mf_rdy;
  end

  // next state of the whole block
  always_comb begin
    st_d = st_q;

    // software writes; status has no writable bits
    if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
      st_d.sys_clk_select = reg_wdata_in[CTRL_SCS_LSB +: 2];
      st_d.ifs = reg_wdata_in[CTRL_IFS_LSB +: 4];
    end
    if (reg_wr_in && reg_addr_in == ADDR_TRIM) begin
      // only the trim output moves; no done flag exists
      st_d.trim = reg_wdata_in[5:0];
    end

    // read data stands one cycle, zero otherwise
    st_d.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL: st_d.rdata = ctrl_rd;
        ADDR_STAT: st_d.rdata = stat_rd;
        ADDR_TRIM: st_d.rdata = {2'b00, st_q.trim};
        default: st_d.rdata = '0;
      endcase
    end

    // oscillator enables; the running source stays on until switched away
    st_d.hf_en = (int_mode && st_q.ifs[3])
               || st_q.cur_src == SRC_HF;
    // high source is built from mid, so mid runs whenever high does
    st_d.mf_en = (int_mode && st_q.ifs != IFS_LF)
               || st_q.cur_src == SRC_HF
               || st_q.cur_src == SRC_MF;
    st_d.lf_en = (int_mode && st_q.ifs == IFS_LF)
               || st_q.cur_src == SRC_LF
               || wdt_needs_lf_in || powerup_delay_timer_needs_lf_in;

    // start-up counters model settle time, cleared when off
    st_d.hf_cnt = !st_q.hf_en ? '0 :
      (st_q.hf_cnt >= HF_STABLE_CYC ? st_q.hf_cnt : st_q.hf_cnt + 1'b1);
    st_d.mf_cnt = !st_q.mf_en ? '0 :
      (st_q.mf_cnt >= MF_READY_CYC ? st_q.mf_cnt : st_q.mf_cnt + 1'b1);
    st_d.lf_cnt = !st_q.lf_en ? '0 :
      (st_q.lf_cnt >= LF_READY_CYC ? st_q.lf_cnt : st_q.lf_cnt + 1'b1);

    // flags follow enable and settle count
    st_d.hf_rdy = st_q.hf_en && st_q.hf_cnt >= HF_READY_CYC;
    st_d.hf_lck = st_q.hf_en && st_q.hf_cnt >= HF_LOCK_CYC;
    st_d.hf_stb = st_q.hf_en
                && st_q.hf_cnt >= HF_STABLE_CYC;
    st_d.mf_rdy = st_q.mf_en && st_q.mf_cnt >= MF_READY_CYC;
    st_d.lf_rdy = st_q.lf_en && st_q.lf_cnt >= LF_READY_CYC;

    // fast start-up oscillator covers the high source settling
    st_d.fso_en = st_q.hf_en && !st_q.hf_rdy;

    // edge history of old and new clock levels
    st_d.cur_lvl_p = cur_lvl;
    st_d.new_lvl_p = new_lvl;

    // glitch-free switch sequencer
    unique case (st_q.st)
      SW_BOOT: begin
        // configuration source taken directly after reset release
        st_d.cur_src = tgt_src;
        st_d.cur_div = tgt_div;
        st_d.pend_src = tgt_src;
        st_d.pend_div = tgt_div;
        st_d.st = SW_RUN;
      end
      SW_RUN: begin
        st_d.pend_src = tgt_src;
        st_d.pend_div = tgt_div;
        if (tgt_src != st_q.cur_src || tgt_div != st_q.cur_div) begin
          st_d.st = SW_WAIT_RDY;
        end
      end
      SW_WAIT_RDY: begin
        // same-source changes see new_rdy at once: no start-up wait
        if (new_rdy) begin
          st_d.st = SW_WAIT_FALL;
        end
      end
      SW_WAIT_FALL: begin
        if (st_q.cur_lvl_p && !cur_lvl) begin
          st_d.hold = 1'b1;
          st_d.st = SW_HOLD;
        end
      end
      SW_HOLD: begin
        // new clock enters on its rising edge, so no runt pulse
        if (!st_q.new_lvl_p && new_lvl) begin
          st_d.hold = 1'b0;
          st_d.cur_src = st_q.pend_src;
          st_d.cur_div = st_q.pend_div;
          st_d.st = SW_RUN;
        end
      end
      default: st_d.st = SW_BOOT;
    endcase

    // mode decode and start-up timer bypass
    st_d.bypass = fosc_cfg_in != FOSC_INT;
    st_d.ext_mode = fosc_cfg_in;
    st_d.gpio_free = fosc_cfg_in == FOSC_INT;

    // clock out pin: clock image or general purpose drive
    if (clock_out_pin_cfg_in) begin
      st_d.cko = cur_lvl && !st_q.hold;
      st_d.cko_oe = 1'b1;
    end else begin
      st_d.cko = gpio_out_in;
      st_d.cko_oe = gpio_oe_in;
    end
  end

  // with no edges nothing changes, so a stopped clock keeps all state
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q <= '0;
      st_q.st <= SW_BOOT;
      st_q.cur_src <= SRC_EXT;
      st_q.pend_src <= SRC_EXT;
      st_q.sys_clk_select <= SCS_RESET;
      st_q.ifs <= IFS_RESET;
      st_q.trim <= TRIM_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out = st_q.rdata;
  assign hf_osc_en_out = st_q.hf_en;
  assign mf_osc_en_out = st_q.mf_en;
  assign lf_osc_en_out = st_q.lf_en;
  assign fast_start_en_out = st_q.fso_en;
  // trim reaches mid and high only; the low oscillator has no trim input
  assign osc_trim_out = st_q.trim;
  assign sys_clk_src_out = st_q.cur_src;
  assign sys_clk_div_out = st_q.cur_div;
  assign sys_clk_hold_out = st_q.hold;
  assign startup_bypass_out = st_q.bypass;
  assign ext_power_mode_out = st_q.ext_mode;
  assign ext_pin_gpio_free_out = st_q.gpio_free;
  assign clock_out_pin_out = st_q.cko;
  assign clock_out_pin_oe_out = st_q.cko_oe;

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_reset_fields;
    $rose(resetn_in) |-> st_q.sys_clk_select == SCS_RESET && st_q.ifs == IFS_RESET;
  endproperty
  a_reset_fields: assert property (p_reset_fields)
    else $error("select fields not at reset values");

  property p_hf_enable;
    (int_mode && st_q.ifs[3]) |=> hf_osc_en_out;
  endproperty
  a_hf_enable: assert property (p_hf_enable)
    else $error("high source not enabled");

  property p_flag_clear;
    !hf_osc_en_out |=> !st_q.hf_rdy && !st_q.hf_lck && !st_q.hf_stb;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("high flags stay set while off");

  property p_flag_order;
    (st_q.hf_stb |-> st_q.hf_lck) and (st_q.hf_lck |-> st_q.hf_rdy);
  endproperty
  a_flag_order: assert property (p_flag_order)
    else $error("stable or locked without ready");

  property p_trim_write;
    (reg_wr_in && reg_addr_in == ADDR_TRIM)
      |=> osc_trim_out == $past(reg_wdata_in[5:0]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("trim value not taken");

  property p_bypass;
    (fosc_cfg_in != FOSC_INT) |=> startup_bypass_out;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("start-up timer not bypassed");

  property p_lf_keep;
    (wdt_needs_lf_in || powerup_delay_timer_needs_lf_in) |=> lf_osc_en_out;
  endproperty
  a_lf_keep: assert property (p_lf_keep)
    else $error("low oscillator off while needed");

  property p_hold_on_fall;
    $rose(sys_clk_hold_out) |-> !st_q.cur_lvl_p && $past(st_q.cur_lvl_p);
  endproperty
  a_hold_on_fall: assert property (p_hold_on_fall)
    else $error("hold began without falling edge");

  property p_release_on_rise;
    $fell(sys_clk_hold_out) |-> st_q.new_lvl_p && !$past(st_q.new_lvl_p);
  endproperty
  a_release_on_rise: assert property (p_release_on_rise)
    else $error("hold ended without rising edge");

  property p_mf_ready;
    st_q.mf_rdy |-> $past(mf_osc_en_out);
  endproperty
  a_mf_ready: assert property (p_mf_ready)
    else $error("mid ready without oscillator");
endmodule // scss_top

// [verif/scss_osc_model.sv]
`timescale 1ns/1ns
module scss_osc_model (
  // enables from the block
  input wire logic hf_en_in,
  input wire logic mf_en_in,
  input wire logic lf_en_in,
  // raw levels back to the block
  output logic ext_clk_out,
  output logic hf_lvl_out,
  output logic mf_lvl_out,
  output logic lf_lvl_out
);
  // start low so the synchronisers never see an unknown
  initial begin
    ext_clk_out = 1'b0;
    hf_lvl_out = 1'b0;
    mf_lvl_out = 1'b0;
    lf_lvl_out = 1'b0;
  end
  // outside logic-level source, free running
  always #90 ext_clk_out = !ext_clk_out;
  // slow behavioural rates so every level is seen by the 2-flop sync
  always #60 hf_lvl_out = hf_en_in ? !hf_lvl_out : 1'b0;
  always #110 mf_lvl_out = mf_en_in ? !mf_lvl_out : 1'b0;
  always #170 lf_lvl_out = lf_en_in ? !lf_lvl_out : 1'b0;
endmodule // scss_osc_model

// [verif/tb_system_clock_source_select.sv]
`timescale 1ns/1ns
module tb_system_clock_source_select;
  import scss_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] fosc = FOSC_INT;
  logic pin_cfg = 1'b1;
  logic wdt_lf = 1'b0;
  logic powerup_delay_timer_lf = 1'b0;
  logic gpio_o = 1'b0;
  logic gpio_oe = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic ext_clk, hf_lvl, mf_lvl, lf_lvl;
  logic hf_en, mf_en, lf_en, fast_en, hold, bypass, gfree, pin_o, pin_oe;
  logic [5:0] trim;
  logic [5:0] t;
  logic [1:0] src, pmode;
  logic [2:0] div;
  logic [7:0] v;
  int n_errors = 0;
  int check_count = 0;
  int m_ctrl;
  int m_trim;
  int d;
  int codes[$] = '{6, 4, 1};

  // 20 MHz core clock
  always #25 core_clk_in = ~core_clk_in;

  scss_top dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .fosc_cfg_in(fosc),
    .clock_out_pin_cfg_in(pin_cfg), .wdt_needs_lf_in(wdt_lf),
    .powerup_delay_timer_needs_lf_in(powerup_delay_timer_lf), .ext_clock_in_pin_in(ext_clk),
    .hf_osc_lvl_in(hf_lvl), .mf_osc_lvl_in(mf_lvl),
    .lf_osc_lvl_in(lf_lvl), .gpio_out_in(gpio_o), .gpio_oe_in(gpio_oe),
    .hf_osc_en_out(hf_en), .mf_osc_en_out(mf_en), .lf_osc_en_out(lf_en),
    .fast_start_en_out(fast_en), .osc_trim_out(trim),
    .sys_clk_src_out(src), .sys_clk_div_out(div),
    .sys_clk_hold_out(hold), .startup_bypass_out(bypass),
    .ext_power_mode_out(pmode), .ext_pin_gpio_free_out(gfree),
    .clock_out_pin_out(pin_o), .clock_out_pin_oe_out(pin_oe));

  scss_osc_model osc_u (.hf_en_in(hf_en), .mf_en_in(mf_en),
    .lf_en_in(lf_en), .ext_clk_out(ext_clk), .hf_lvl_out(hf_lvl),
    .mf_lvl_out(mf_lvl), .lf_lvl_out(lf_lvl));

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // only control and trim hold software state; other places drop writes
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] dt);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
    if (a == ADDR_CTRL) m_ctrl = int'(dt) & 'h7B;
    if (a == ADDR_TRIM) m_trim = int'(dt) & 'h3F;
  endtask

  // read data taken at the edge that closes its one-cycle slot
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] dt);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    @(posedge core_clk_in);
    dt = rdata;
  endtask

  task automatic wait_src(input logic [1:0] s);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk_in);
      #1;
      if (src === s && hold === 1'b0) break;
    end
    if (i == 3000) begin
      n_errors++;
      $display("[FAIL] %0t clock switch timed out", $time);
      wrap_up();
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    cyc(n);
    resetn_in <= 1'b1;
    m_ctrl = (int'(IFS_RESET) << CTRL_IFS_LSB) | int'(SCS_RESET);
    m_trim = 0;
  endtask

  initial begin
    void'($urandom(32'h97BD3FF0));
    do_reset(12);
    rd_reg(ADDR_CTRL, v);
    check(v, 8'(m_ctrl));
    rd_reg(ADDR_TRIM, v);
    check(v, 8'h00);
    // mid source comes up from the configuration word alone
    cyc(60);
    check({3'h0, src, div}, {3'h0, SRC_MF, 3'h0});
    check({6'h0, bypass, gfree}, 8'h01);
    rd_reg(ADDR_STAT, v);
    check(v & 8'h10, 8'h10);
    // trim: both extremes then random codes
    for (int k = 0; k < 6; k++) begin
      t = (k == 0) ? 6'h1F : (k == 1) ? 6'h20 : 6'($urandom);
      wr_reg(ADDR_TRIM, {2'h0, t});
      rd_reg(ADDR_TRIM, v);
      check(v, 8'(m_trim));
      check({2'h0, trim}, 8'(m_trim));
    end
    // writes to status and the hole must not land anywhere
    wr_reg(ADDR_STAT, 8'hFF);
    wr_reg(2'h3, 8'hFF);
    rd_reg(ADDR_CTRL, v);
    check(v, 8'(m_ctrl));
    rd_reg(2'h3, v);
    check(v, 8'h00);
    // timers keep the low oscillator alive on their own
    wdt_lf <= 1'b1;
    cyc(250);
    check({7'h0, lf_en}, 8'h01);
    rd_reg(ADDR_STAT, v);
    check(v & 8'h08, 8'h08);
    wdt_lf <= 1'b0;
    powerup_delay_timer_lf <= 1'b1;
    cyc(3);
    check({7'h0, lf_en}, 8'h01);
    powerup_delay_timer_lf <= 1'b0;
    cyc(5);
    rd_reg(ADDR_STAT, v);
    check({v[3], 6'h0, lf_en}, 8'h00);
    // run-time switch to the 16 MHz source
    wr_reg(ADDR_CTRL, 8'h7A);
    cyc(3);
    check({6'h0, hf_en, fast_en}, 8'h03);
    wait_src(SRC_HF);
    check({5'h0, div}, 8'h00);
    check({6'h0, hf_en, fast_en}, 8'h02);
    cyc(1100);
    rd_reg(ADDR_STAT, v);
    check(v & 8'h07, 8'h07);
    wr_reg(ADDR_CTRL, 8'h73);
    cyc(20);
    check({3'h0, src, div}, {3'h0, SRC_HF, 3'h1});
    rd_reg(ADDR_CTRL, v);
    check(v, 8'(m_ctrl));
    // mid postscaler codes, the last of them a shared lowest step
    foreach (codes[j]) begin
      wr_reg(ADDR_CTRL, 8'((codes[j] << 3) | 2));
      d = (codes[j] >= 4) ? 7 - codes[j] : 4;
      wait_src(SRC_MF);
      // same-source steps need a fall and a rise of the slow mid clock
      cyc(20);
      check({5'h0, div}, 8'(d));
    end
    rd_reg(ADDR_STAT, v);
    check({v[2:0], 4'h0, hf_en}, 8'h00);
    wr_reg(ADDR_CTRL, 8'h02);
    wait_src(SRC_LF);
    check({7'h0, lf_en}, 8'h01);
    // every external power band from reset, then back to internal
    for (int c = 1; c < 4; c++) begin
      fosc <= 2'(c);
      do_reset(2);
      cyc(3);
      check({2'h0, bypass, gfree, pmode, src}, {4'h2, 2'(c), SRC_EXT});
      rd_reg(ADDR_CTRL, v);
      check(v, 8'(m_ctrl));
    end
    wr_reg(ADDR_CTRL, 8'h3A);
    wait_src(SRC_MF);
    check({6'h0, bypass, mf_en}, 8'h03);
    fosc <= FOSC_INT;
    do_reset(2);
    cyc(3);
    check({6'h0, bypass, gfree}, 8'h01);
    // clock out pin as general I/O, then as clock output
    pin_cfg <= 1'b0;
    gpio_o <= 1'($urandom);
    gpio_oe <= 1'($urandom);
    cyc(3);
    check({6'h0, pin_o, pin_oe}, {6'h0, gpio_o, gpio_oe});
    pin_cfg <= 1'b1;
    cyc(3);
    check({7'h0, pin_oe}, 8'h01);
    // running mid clock must show both levels on the pin
    d = 0;
    repeat (20) begin
      cyc(1);
      d = d | (pin_o ? 2 : 1);
    end
    check(8'(d), 8'h03);
    wrap_up();
  end
endmodule // tb_system_clock_source_select
